// ==== hdl/wave_timer.sv ====
// 8-bit timer with waveform generation, reached over APB.
//
// Operation
// - Fast PWM with compare field one toggles output on each match.
// - Fast PWM double-buffers compare value; it loads at BOTTOM.
// - Mode one counts up to MAX then down to BOTTOM repeatedly.
// - Phase mode: field two clears up, sets down; three inverts.
// - Phase mode is eight bits; MAX held for one tick.
// - Overflow flag at BOTTOM in phase mode, at MAX otherwise.
// - Phase period is 510 prescaled ticks; prescale 1 to 1024.
// - Phase mode, field two: compare BOTTOM gives steady low, MAX steady high; field three the reverse.
// - Phase mode output at MAX equals the up-counting match result unless compare is MAX.
// - Phase mode only: a missed up-count match still yields its output change.
// - Tick is a one-cycle enable; async mode uses oscillator pin.
// - Force bit gives an immediate match, only in non-PWM modes.
// - Forced match sets no flag and never clears the counter.
// - Force bit is write-only and reads back zero.
// - Mode field: normal, phase PWM, CTC, fast PWM with TOP at MAX.
// - Mode high bit sits at position 3, low bit at position 6.
// - Clock select: stop, undivided, then 8 through 1024.
// - PWM set/clear with compare at TOP ignores match, acts at TOP instead.
// - Counter write suppresses compare match on the next tick.
//
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/100ps

module wave_timer
(
  // APB clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB request.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  // APB answer.
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Separate timer oscillator pin.
  input  wire logic        timer_source_clock,
  // Waveform output pin and its connection enable.
  output logic             compare_output_pin,
  output logic             compare_output_enable
);
  import wavetimer_pkg::*;

  typedef struct packed
  {
    logic [6:0]  control;
    logic [7:0]  count;
    logic [7:0]  compare_buffer;
    logic [7:0]  compare_active;
    logic        count_up;
    logic        match_block;
    logic        overflow_flag;
    logic        compare_match_flag;
    logic        async_select;
    logic [2:0]  source_sync;
    logic        source_level;
    logic        level;
    logic        pin_enable;
    logic        ready;
    logic        slverr;
    logic [31:0] rdata;
  } timer_state_t;

  timer_state_t state_reg;
  timer_state_t state_next;

  logic       timer_tick_enable;
  logic       source_tick;
  logic       source_filtered;
  logic       setup;
  logic       access_wr;
  logic       hit;
  logic       set_overflow;
  logic       set_match;
  logic       at_top_next;
  logic [7:0] count_step;
  logic [1:0] com;
  wave_mode_t mode;

  // Mode field is split across the control word.
  function automatic wave_mode_t mode_of(input logic [6:0] ctl);
    mode_of = wave_mode_t'({ctl[MODE_HIGH_BIT],
                            ctl[MODE_LOW_BIT]});
  endfunction

  // Level after a non-PWM or fast PWM match: toggle, clear or set.
  function automatic logic match_level(input logic [1:0] c,
                                       input logic       lvl);
    case (c)
      2'h1:    match_level = ~lvl;
      2'h2:    match_level = 1'b0;
      2'h3:    match_level = 1'b1;
      default: match_level = lvl;
    endcase
  endfunction

  // Decoded request phases and current configuration.
  assign setup     = psel && !penable;
  assign access_wr = psel && penable && pwrite && state_reg.ready;
  assign mode      = mode_of(state_reg.control);
  assign com       = state_reg.control[COM_HIGH_BIT:COM_LOW_BIT];

  // A source change counts once the second and third stages agree.
  assign source_filtered = (state_reg.source_sync[1] ==
                            state_reg.source_sync[2])
                           ? state_reg.source_sync[2]
                           : state_reg.source_level;

  // Synchronous mode ticks every cycle; async uses oscillator edges.
  assign source_tick = state_reg.async_select
                       ? (source_filtered && !state_reg.source_level)
                       : 1'b1;

  timer_prescaler u_prescaler
  (
    .pclk               (pclk),
    .presetn            (presetn),
    .source_tick        (source_tick),
    .clock_select_field (state_reg.control[CS_HIGH_BIT:0]),
    .timer_tick_enable  (timer_tick_enable)
  );

  // A match needs a tick, equality and no recent counter write.
  assign hit = timer_tick_enable && !state_reg.match_block &&
               (state_reg.count == state_reg.compare_active);

  // Main next-state process: bus, counter, compare unit and flags.
  always_comb
  begin
    state_next   = state_reg;
    set_overflow = 1'b0;
    set_match    = 1'b0;
    at_top_next  = 1'b0;
    count_step   = state_reg.count + 8'h01;

    // Input synchroniser chain and filtered level.
    state_next.source_sync  = {state_reg.source_sync[1:0],
                               timer_source_clock};
    state_next.source_level = source_filtered;

    // Counting and waveform on each timer tick.
    if (timer_tick_enable)
    begin
      state_next.match_block = 1'b0;
      case (mode)
        MODE_PHASE_PWM:
        begin
          // Dual slope; MAX is held for one tick as direction turns.
          if (state_reg.count_up && state_reg.count != MAX)
            state_next.count = count_step;
          else if (state_reg.count_up)
          begin
            state_next.count    = state_reg.count - 8'h01;
            state_next.count_up = 1'b0;
          end
          else if (state_reg.count != BOTTOM)
            state_next.count = state_reg.count - 8'h01;
          else
          begin
            state_next.count    = count_step;
            state_next.count_up = 1'b1;
          end
          if (!state_reg.count_up && state_reg.count == 8'h01)
          begin
            state_next.count_up = 1'b1;
            set_overflow        = 1'b1;
          end
          if (state_reg.count_up && state_reg.count == 8'hFE)
            at_top_next = 1'b1;
          // Matches at MAX are ignored; MAX has its own action below.
          if (hit && state_reg.count != MAX)
          begin
            set_match = 1'b1;
            if (com[1])
            begin
              // Up result is com low bit; BOTTOM counts as up.
              if (state_reg.count_up || state_reg.count == BOTTOM)
                state_next.level = com[0];
              else
                state_next.level = ~com[0];
            end
          end
          // Compare loads at TOP; output at MAX takes up-match level, inverted if compare is MAX.
          if (at_top_next)
          begin
            state_next.compare_active = state_reg.compare_buffer;
            if (com[1])
            begin
              if (state_reg.compare_buffer == MAX)
                state_next.level = ~com[0];
              else
                state_next.level = com[0];
            end
          end
        end
        MODE_CTC:
        begin
          // TOP comes from the compare value.
          if (hit)
            state_next.count = BOTTOM;
          else
            state_next.count = count_step;
          if (state_reg.count == MAX)
            set_overflow = 1'b1;
          if (hit)
          begin
            set_match        = 1'b1;
            state_next.level = match_level(com, state_reg.level);
          end
        end
        MODE_FAST_PWM:
        begin
          state_next.count = count_step;
          if (hit)
            set_match = 1'b1;
          // Match at TOP is ignored in the set and clear settings.
          if (hit && !(com[1] && state_reg.compare_active == MAX))
            state_next.level = match_level(com, state_reg.level);
          if (state_reg.count == MAX)
          begin
            set_overflow              = 1'b1;
            state_next.compare_active = state_reg.compare_buffer;
            if (com[1])
              state_next.level = ~com[0];
          end
        end
        default:
        begin
          state_next.count = count_step;
          if (state_reg.count == MAX)
            set_overflow = 1'b1;
          if (hit)
          begin
            set_match        = 1'b1;
            state_next.level = match_level(com, state_reg.level);
          end
        end
      endcase
      if (mode != MODE_PHASE_PWM)
        state_next.count_up = 1'b1;
    end

    // APB answer is prepared in setup and shown through the access phase.
    state_next.ready  = setup;
    state_next.slverr = 1'b0;
    state_next.rdata  = 32'h0000_0000;
    if (setup)
    begin
      case (paddr)
        CONTROL_ADDR:
          state_next.rdata = {25'h0, state_reg.control};
        COUNTER_ADDR:
          state_next.rdata = {24'h0, state_reg.count};
        COMPARE_ADDR:
          state_next.rdata = {24'h0, state_reg.compare_buffer};
        FLAGS_ADDR:
          state_next.rdata = {30'h0, state_reg.compare_match_flag,
                              state_reg.overflow_flag};
        SOURCE_ADDR:
          state_next.rdata = {31'h0, state_reg.async_select};
        default:
          state_next.slverr = 1'b1;
      endcase
    end

    // Register writes take effect at the access edge.
    if (access_wr)
    begin
      case (paddr)
        CONTROL_ADDR:
        begin
          state_next.control = pwdata[6:0];
          // Forced match uses the new field value, no flag, no clear.
          if (pwdata[FORCE_BIT] &&
              (mode_of(pwdata[6:0]) == MODE_NORMAL ||
               mode_of(pwdata[6:0]) == MODE_CTC))
            state_next.level = match_level(
              pwdata[COM_HIGH_BIT:COM_LOW_BIT],
              state_reg.level);
        end
        COUNTER_ADDR:
        begin
          state_next.count       = pwdata[7:0];
          state_next.match_block = 1'b1;
        end
        COMPARE_ADDR:
        begin
          state_next.compare_buffer = pwdata[7:0];
          if (mode == MODE_NORMAL || mode == MODE_CTC)
            state_next.compare_active = pwdata[7:0];
        end
        SOURCE_ADDR:
          state_next.async_select = pwdata[ASYNC_BIT];
        default:
        begin
        end
      endcase
    end

    // Flags clear by writing one; a same-cycle event wins over the clear.
    state_next.overflow_flag = (state_reg.overflow_flag &&
      !(access_wr && paddr == FLAGS_ADDR && pwdata[OVERFLOW_BIT]))
      || set_overflow;
    state_next.compare_match_flag = (state_reg.compare_match_flag &&
      !(access_wr && paddr == FLAGS_ADDR && pwdata[MATCH_BIT]))
      || set_match;

    // Pin is connected whenever the compare field is non-zero.
    state_next.pin_enable = (state_next.control[COM_HIGH_BIT:COM_LOW_BIT]
                             != 2'h0);
  end

  // All state registered in one place.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg                <= '0;
      state_reg.control        <= CONTROL_RESET;
      state_reg.count          <= COUNTER_RESET;
      state_reg.compare_buffer <= COMPARE_RESET;
      state_reg.compare_active <= COMPARE_RESET;
      state_reg.count_up       <= 1'b1;
    end
    else
      state_reg <= state_next;
  end

  // Outputs come straight from the state register.
  assign prdata                = state_reg.rdata;
  assign pready                = state_reg.ready;
  assign pslverr               = state_reg.slverr;
  assign compare_output_pin    = state_reg.level;
  assign compare_output_enable = state_reg.pin_enable;

endmodule

// ==== inc/wavetimer_pkg.sv ====
// Shared constants and types for the 8-bit waveform timer.
package wavetimer_pkg;

  // Register byte addresses on the APB bus.
  localparam logic [7:0] CONTROL_ADDR  = 8'h00;
  localparam logic [7:0] COUNTER_ADDR  = 8'h04;
  localparam logic [7:0] COMPARE_ADDR  = 8'h08;
  localparam logic [7:0] FLAGS_ADDR    = 8'h0C;
  localparam logic [7:0] SOURCE_ADDR   = 8'h10;

  // Control register field positions.
  localparam int FORCE_BIT      = 7;
  localparam int MODE_LOW_BIT   = 6;
  localparam int COM_HIGH_BIT   = 5;
  localparam int COM_LOW_BIT    = 4;
  localparam int MODE_HIGH_BIT  = 3;
  localparam int CS_HIGH_BIT    = 2;

  // Flag register bit positions.
  localparam int OVERFLOW_BIT   = 0;
  localparam int MATCH_BIT      = 1;

  // Source register: bit 0 selects the separate timer oscillator.
  localparam int ASYNC_BIT      = 0;

  // Values after reset.
  localparam logic [6:0] CONTROL_RESET = 7'h00;
  localparam logic [7:0] COUNTER_RESET = 8'h00;
  localparam logic [7:0] COMPARE_RESET = 8'h00;

  // Counter limits.
  localparam logic [7:0] BOTTOM        = 8'h00;
  localparam logic [7:0] MAX           = 8'hFF;

  // Prescaler divider width, enough for the largest division of 1024.
  localparam int PRESCALE_WIDTH = 10;

  // Waveform modes as carried by the two-bit mode field.
  typedef enum logic [1:0]
  {
    MODE_NORMAL,
    MODE_PHASE_PWM,
    MODE_CTC,
    MODE_FAST_PWM
  } wave_mode_t;

endpackage

// ==== hdl/timer_prescaler.sv ====
// Prescaler that turns source ticks into the selected timer tick enable.
`timescale 1ns/100ps

module timer_prescaler
(
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Source tick and division select.
  input  wire logic        source_tick,
  input  wire logic [2:0]  clock_select_field,
  // One-cycle timer tick enable.
  output logic             timer_tick_enable
);
  import wavetimer_pkg::*;

  typedef struct packed
  {
    logic [PRESCALE_WIDTH-1:0] div;
    logic                      tick;
  } presc_state_t;

  presc_state_t state_reg;
  presc_state_t state_next;
  logic [PRESCALE_WIDTH-1:0] mask;

  // Division mask: a tick fires when all masked divider bits are ones.
  always_comb
  begin
    state_next = state_reg;
    case (clock_select_field)
      3'h2:    mask = 10'h007;
      3'h3:    mask = 10'h01F;
      3'h4:    mask = 10'h03F;
      3'h5:    mask = 10'h07F;
      3'h6:    mask = 10'h0FF;
      3'h7:    mask = 10'h3FF;
      default: mask = 10'h000;
    endcase
    state_next.tick = 1'b0;
    if (source_tick)
    begin
      state_next.div = state_reg.div + 10'h001;
      // Stop gives no tick; select one passes every source tick.
      if (clock_select_field != 3'h0)
        state_next.tick = ((state_reg.div & mask) == mask);
    end
  end

  // Divider keeps running while stopped so the phase is not reset.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign timer_tick_enable = state_reg.tick;

endmodule

// ==== testbench/wave_timer_sva.sv ====
// Port checker for the waveform timer.
`timescale 1ns/100ps
module wave_timer_sva
  import wavetimer_pkg::*;
(
  // Clock, reset and APB.
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Pins.
  input wire logic        timer_source_clock,
  input wire logic        compare_output_pin,
  input wire logic        compare_output_enable
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Bus phases that the properties are built from.
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_read;
    pready && !pwrite;
  endsequence
  sequence s_ctl_wr;
    psel && penable && pready && pwrite && paddr == CONTROL_ADDR;
  endsequence

  // Bus answer timing and refusal of unmapped places.
  property p_ready_after_setup;
    s_setup |=> pready;
  endproperty
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  property p_err_with_ready;
    pslverr |-> pready;
  endproperty
  property p_unmapped;
    psel && penable && paddr > SOURCE_ADDR |-> pslverr;
  endproperty
  property p_err_zero;
    pslverr && !pwrite |-> prdata == 32'h0;
  endproperty
  property p_upper_zero;
    s_read |-> prdata[31:8] == 24'h0;
  endproperty
  property p_force_zero;
    s_read ##0 paddr == CONTROL_ADDR |-> !prdata[FORCE_BIT];
  endproperty
  // The pin drive follows the compare field within two cycles.
  property p_oe_on;
    s_ctl_wr ##0 pwdata[5:4] != 2'b00 |-> ##[1:2] compare_output_enable;
  endproperty
  property p_oe_off;
    s_ctl_wr ##0 pwdata[5:4] == 2'b00 |-> ##[1:2] !compare_output_enable;
  endproperty

  a_ready_after_setup: assert property (p_ready_after_setup)
    else $error("pready missing after setup");
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("pready longer than one cycle");
  a_err_with_ready: assert property (p_err_with_ready)
    else $error("pslverr without pready");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not refused");
  a_err_zero: assert property (p_err_zero)
    else $error("refused read not zero");
  a_upper_zero: assert property (p_upper_zero)
    else $error("upper read bits not zero");
  a_force_zero: assert property (p_force_zero)
    else $error("force bit read as one");
  a_oe_on: assert property (p_oe_on)
    else $error("pin drive not enabled");
  a_oe_off: assert property (p_oe_off)
    else $error("pin drive not released");
endmodule

// ==== testbench/pin_load_model.sv ====
// Load on the waveform pin, pulled low when the pin is not driven.
`timescale 1ns/100ps
module pin_load_model
(
  // Pin and its drive enable.
  input  wire logic pin,
  input  wire logic drive_en,
  // Level seen by the load.
  output logic      level
);
  // The pull-down wins when nothing drives, so a released pin reads low.
  assign level = drive_en ? pin : 1'b0;
endmodule

// ==== testbench/tb.sv ====
// Self-checking testbench for the waveform timer.
`timescale 1ns/100ps
module tb;
  import wavetimer_pkg::*;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        src_clk;
  logic        pin;
  logic        oe;
  logic        lvl;
  logic        err;
  int          fails;
  int          n_tests;

  // Clock at 125 MHz.
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  wave_timer wave_timer_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_source_clock(src_clk),
    .compare_output_pin(pin), .compare_output_enable(oe));
  pin_load_model pin_load_model_inst (.pin(pin), .drive_en(oe),
    .level(lvl));

  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      fails++;
      $display("FAIL at %0t got %h expected %h", $time, g, e);
    end
  endtask

  // One APB transfer, held until pready is seen high.
  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for an answer that never comes.
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(a, 1'b1, d, r);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    apb(a, 1'b0, 32'h0, r);
  endtask

  // Waits for a pin level; the watchdog bounds a pin that never moves.
  task automatic edge_to(input logic v);
    while (lvl !== v)
      @(posedge pclk);
  endtask

  // Length in cycles of one whole phase of the pin at level v.
  task automatic len(input logic v, output int n);
    time t;
    edge_to(!v);
    edge_to(v);
    t = $time;
    edge_to(!v);
    n = int'(($time - t) / 8);
  endtask

  // Reset values and a refused access.
  task automatic t_regs();
    logic [7:0]  a[4] = '{CONTROL_ADDR, COUNTER_ADDR, COMPARE_ADDR,
                          FLAGS_ADDR};
    logic [31:0] r;
    foreach (a[i])
    begin
      rd(a[i], r);
      chk(r, 32'h0);
    end
    rd(8'h14, r);
    chk(r, 32'h0);
    chk({31'h0, err}, 32'h1);
  endtask

  // Forced matches in each field; a PWM mode write keeps force at zero.
  task automatic t_force();
    logic [7:0]  c[4] = '{8'h90, 8'hA0, 8'hB0, 8'h68};
    logic        e[4] = '{1'b1, 1'b0, 1'b1, 1'b1};
    logic [31:0] r;
    foreach (c[i])
    begin
      wr(CONTROL_ADDR, {24'h0, c[i]});
      repeat (3) @(posedge pclk);
      chk({31'h0, lvl}, {31'h0, e[i]});
    end
    rd(CONTROL_ADDR, r);
    chk(r, 32'h68);
    rd(FLAGS_ADDR, r);
    chk(r, 32'h0);
  endtask

  // A counter write hides the next match; the later one still toggles.
  task automatic t_cnt();
    logic l;
    wr(CONTROL_ADDR, 32'h10);
    wr(COMPARE_ADDR, 32'h10);
    wr(CONTROL_ADDR, 32'h11);
    wr(COUNTER_ADDR, 32'h10);
    l = lvl;
    repeat (20) @(posedge pclk);
    chk({31'h0, lvl}, {31'h0, l});
    repeat (260) @(posedge pclk);
    chk({31'h0, lvl}, {31'h0, ~l});
  endtask

  // Fast PWM pulse width and the compare value loading at BOTTOM.
  task automatic t_fast();
    int  n;
    time t;
    wr(COMPARE_ADDR, 32'h40);
    wr(CONTROL_ADDR, 32'h69);
    len(1'b1, n);
    chk(n, 65);
    edge_to(1'b0);
    edge_to(1'b1);
    t = $time;
    wr(COMPARE_ADDR, 32'h20);
    edge_to(1'b0);
    chk(int'(($time - t) / 8), 65);
    len(1'b1, n);
    chk(n, 33);
  endtask

  // Toggle in fast PWM at three clock selects, then a stopped timer.
  task automatic t_toggle();
    int   dv[3] = '{1, 8, 32};
    int   n;
    logic l;
    foreach (dv[i])
    begin
      wr(CONTROL_ADDR, 32'h59 + i);
      len(1'b1, n);
      chk(n, 256 * dv[i]);
    end
    wr(CONTROL_ADDR, 32'h58);
    l = lvl;
    repeat (600) @(posedge pclk);
    chk({31'h0, lvl}, {31'h0, l});
  endtask

  // Dual-slope phases and the overflow flag at BOTTOM.
  task automatic t_phase();
    int          n;
    logic [31:0] r;
    wr(CONTROL_ADDR, 32'h00);
    // Start from BOTTOM so the first low phase is a whole one.
    wr(COUNTER_ADDR, 32'h0);
    wr(COMPARE_ADDR, 32'h80);
    wr(CONTROL_ADDR, 32'h61);
    len(1'b0, n);
    chk(n, 254);
    len(1'b1, n);
    chk(n, 256);
    wr(FLAGS_ADDR, 32'h1);
    repeat (200) @(posedge pclk);
    rd(FLAGS_ADDR, r);
    chk(r & 32'h1, 32'h0);
    repeat (200) @(posedge pclk);
    rd(FLAGS_ADDR, r);
    chk(r & 32'h1, 32'h1);
  endtask

  // Steady levels at the extreme compare values, both polarities.
  task automatic t_ext();
    logic [7:0] c[4] = '{8'h61, 8'h61, 8'h71, 8'h71};
    logic [7:0] v[4] = '{8'h00, 8'hFF, 8'h00, 8'hFF};
    logic       e[4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    int         bad;
    foreach (c[i])
    begin
      wr(COMPARE_ADDR, {24'h0, v[i]});
      wr(CONTROL_ADDR, {24'h0, c[i]});
      repeat (600) @(posedge pclk);
      bad = 0;
      repeat (520)
      begin
        @(posedge pclk);
        if (lvl !== e[i])
          bad++;
      end
      chk(bad, 0);
    end
  endtask

  // Oscillator pin clocking: one counter step per filtered rising edge.
  task automatic t_async();
    logic [31:0] r;
    wr(SOURCE_ADDR, 32'h1);
    wr(CONTROL_ADDR, 32'h01);
    wr(COUNTER_ADDR, 32'h0);
    repeat (20)
    begin
      repeat (4) @(posedge pclk);
      src_clk <= ~src_clk;
    end
    repeat (10) @(posedge pclk);
    rd(COUNTER_ADDR, r);
    chk(r, 32'h0A);
    rd(SOURCE_ADDR, r);
    chk(r, 32'h1);
  endtask

  // Main sequence after ten cycles of reset.
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    src_clk = 1'b0;
    fails = 0;
    n_tests = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_force();
    t_cnt();
    t_fast();
    t_toggle();
    t_phase();
    t_ext();
    t_async();
    finish_test();
  end

  // Watchdog sized well past the longest expected run.
  initial
  begin
    repeat (90000) @(posedge pclk);
    fails++;
    finish_test();
  end
endmodule

bind wave_timer wave_timer_sva wave_timer_sva_inst (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .timer_source_clock(timer_source_clock),
  .compare_output_pin(compare_output_pin),
  .compare_output_enable(compare_output_enable));
